// *** fsp_pkg.sv ***
`default_nettype none
package fsp_pkg;
   // clock and programming time
   localparam int CLK_KHZ   = 25_000;
   localparam int OP_MIN_NS = 3_700_000; // 3.7 ms least
   localparam int OP_MAX_NS = 4_500_000; // 4.5 ms most
   // least time rounded up; stays well under the most
   localparam int OP_CYCLES = (OP_MIN_NS / 1000 * CLK_KHZ + 999) / 1000;
   localparam int CNT_W     = 17;

   // pointer layout: byte address, word offset then page
   localparam int PAGE_WORDS = 32;
   localparam int WORD_W     = 5;
   localparam int WORD_LSB   = 1;
   localparam int PAGE_W     = 10;
   localparam int PAGE_LSB   = 6;
   localparam logic [PAGE_W-1:0] NO_READ_WHILE_WRITE_REGION_FIRST_PAGE = 10'h300;
   localparam logic [CNT_W-1:0]  STREAM_LEN      = 17'h00020;

   // control register bit positions
   localparam int EN_BIT   = 0;
   localparam int BUSY_BIT = 6;
   localparam int IE_BIT   = 7;

   // command patterns, compared on bits 6..0
   localparam logic [6:0] CMD_LOAD  = 7'h01;
   localparam logic [6:0] CMD_ERASE = 7'h03;
   localparam logic [6:0] CMD_WRITE = 7'h05;
   localparam logic [6:0] CMD_LOCK  = 7'h09;
   localparam logic [6:0] CMD_REEN  = 7'h11;

   // arming windows in cycles after the control write
   localparam logic [2:0] SPM_WIN  = 3'h4;
   localparam logic [2:0] LPM_LAST = 3'h1; // load honoured while window above this

   // readback addresses and fixed values
   localparam logic [15:0] PTR_FUSE_LOW  = 16'h0000;
   localparam logic [15:0] PTR_LOCK      = 16'h0001;
   localparam logic [15:0] PTR_FUSE_EXT  = 16'h0002;
   localparam logic [15:0] PTR_FUSE_HIGH = 16'h0003;
   localparam logic [1:0]  LOCK_PAD      = 2'h3;
   localparam logic [7:0]  RD_UNMAPPED   = 8'hFF;
   localparam logic [7:0]  RD_BLOCKED    = 8'hFF;
   localparam logic [15:0] BUF_ERASED    = 16'hFFFF;

   // host request kinds
   localparam logic [1:0] KIND_CTRL  = 2'h0;
   localparam logic [1:0] KIND_STORE = 2'h1;
   localparam logic [1:0] KIND_LOAD  = 2'h2;

   typedef enum logic [1:0] {D_IDLE, D_ARMED, D_BUSY} fsp_dev_st_t;
   typedef enum logic [1:0] {OP_NONE, OP_ERASE, OP_WRITE, OP_LOCK} fsp_op_t;
   typedef enum logic [2:0] {H_IDLE, H_WAIT, H_CTRL, H_INSTR, H_READ} fsp_host_st_t;
endpackage
`default_nettype wire

// *** fsp_link_if.sv ***
`default_nettype none
interface fsp_link_if;
   // control register access
   logic        ctrl_wr;
   logic [7:0]  ctrl_wdata;
   logic [7:0]  ctrl_rdata;
   // store / load instructions with pointer and data pair
   logic        spm_req;
   logic        lpm_req;
   logic [15:0] ptr;
   logic [15:0] data_word;
   logic        lpm_valid;
   logic [7:0]  lpm_data;
   // status towards the core
   logic        cpu_halt;
   logic        ee_busy;
   logic        irq;

   modport device (
      input  ctrl_wr, ctrl_wdata, spm_req, lpm_req, ptr, data_word,
      output ctrl_rdata, lpm_valid, lpm_data, cpu_halt, ee_busy, irq
   );
   modport core (
      output ctrl_wr, ctrl_wdata, spm_req, lpm_req, ptr, data_word,
      input  ctrl_rdata, lpm_valid, lpm_data, cpu_halt, ee_busy, irq
   );
endinterface
`default_nettype wire

// *** fsp_flash_ctrl.sv ***
// Behaviour
// - erase pattern plus store within four cycles
// - erase ignores data and non-page pointer bits
// - only no-read-while-write region ops halt CPU
// - load pattern plus store fills buffer word
// - buffer clears after write, re-enable, reset
// - core loads each buffer word once only
// - eeprom write discards loaded buffer words
// - write pattern programs buffer into page
// - level interrupt while enabled and idle
// - region busy flag held until re-enable
// - core refuses busy region reads until re-enable
// - lock pattern programs zero bits 5..0
// - lock programming leaves whole flash readable
// - core uses pointer 0001, bits 7:6 set
// - eeprom busy blocks commands and readback
// - core waits for eeprom idle before writing
// - lock readback by load within three cycles
// - lock-set and enable self-clear on timeout
// - cleared bits restore normal program reads
// - pointer selects fuse byte on readback
// - programmed bits read zero, unprogrammed one
// - operations timed 3.7 to 4.5 ms
`default_nettype none
module fsp_flash_ctrl #(
   parameter int OP_CYCLES = fsp_pkg::OP_CYCLES
) (
   // clock and reset
   input  wire logic        REF_CLK_I,
   input  wire logic        RESET_I,
   // link to the core
   fsp_link_if.device       LINK,
   // eeprom controller status
   input  wire logic        EE_BUSY_I,
   input  wire logic        EE_WRITE_I,
   // non-volatile bits, zero means programmed
   input  wire logic [7:0]  FUSE_LOW_I,
   input  wire logic [7:0]  FUSE_HIGH_I,
   input  wire logic [7:0]  FUSE_EXT_I,
   input  wire logic [5:0]  LOCK_STATE_I,
   // flash array read port
   input  wire logic [7:0]  FLASH_RDATA_I,
   output logic             FLASH_RD_O,
   output logic [15:0]      FLASH_RADDR_O,
   // flash array program port
   output logic             FLASH_ERASE_O,
   output logic             FLASH_PROG_O,
   output logic [9:0]       FLASH_PAGE_O,
   output logic             FLASH_WE_O,
   output logic [4:0]       FLASH_WADDR_O,
   output logic [15:0]      FLASH_WDATA_O,
   // lock bit programming
   output logic             LOCK_PROG_O,
   output logic [5:0]       LOCK_DATA_O
);

   localparam logic [fsp_pkg::CNT_W-1:0] LAST_CNT = fsp_pkg::CNT_W'(OP_CYCLES - 1);

   typedef struct packed {
      fsp_pkg::fsp_dev_st_t                        st;
      fsp_pkg::fsp_op_t                            op;
      logic [6:0]                                  cmd;
      logic [2:0]                                  win;
      logic                                        ie;
      logic                                        rww_busy;
      logic                                        halt;
      logic                                        irq;
      logic                                        ee_busy;
      logic [7:0]                                  ctrl_rd;
      logic [fsp_pkg::PAGE_W-1:0]                  page;
      logic [fsp_pkg::CNT_W-1:0]                   cnt;
      logic [fsp_pkg::PAGE_WORDS-1:0]              valid;
      logic [fsp_pkg::PAGE_WORDS-1:0][15:0]        pbuf;
      logic                                        rd_pend;
      logic                                        rd_rb;
      logic [7:0]                                  rb;
      logic                                        fl_rd;
      logic [15:0]                                 raddr;
      logic                                        lpm_valid;
      logic [7:0]                                  lpm_data;
      logic                                        erase;
      logic                                        prog;
      logic                                        we;
      logic [fsp_pkg::WORD_W-1:0]                  waddr;
      logic [15:0]                                 wdata;
      logic                                        lock_prog;
      logic [5:0]                                  lock_data;
   } fsp_dev_state_t;

   fsp_dev_state_t r_reg;
   fsp_dev_state_t r_next;

   ////////////////////////////////////////////////////////////////////////////
   // pointer decoding

   function automatic logic [fsp_pkg::PAGE_W-1:0] page_of(input logic [15:0] p);
      page_of = p[fsp_pkg::PAGE_LSB +: fsp_pkg::PAGE_W];
   endfunction

   function automatic logic [fsp_pkg::WORD_W-1:0] word_of(input logic [15:0] p);
      word_of = p[fsp_pkg::WORD_LSB +: fsp_pkg::WORD_W];
   endfunction

   function automatic logic in_no_read_while_write_region(input logic [fsp_pkg::PAGE_W-1:0] pg);
      in_no_read_while_write_region = (pg >= fsp_pkg::NO_READ_WHILE_WRITE_REGION_FIRST_PAGE);
   endfunction

   // readback byte; bits pass through as stored, zero meaning programmed
   function automatic logic [7:0] rb_byte(input logic [15:0] p);
      case (p)
         fsp_pkg::PTR_FUSE_LOW:  rb_byte = FUSE_LOW_I;
         fsp_pkg::PTR_LOCK:      rb_byte = {fsp_pkg::LOCK_PAD, LOCK_STATE_I};
         fsp_pkg::PTR_FUSE_EXT:  rb_byte = FUSE_EXT_I;
         fsp_pkg::PTR_FUSE_HIGH: rb_byte = FUSE_HIGH_I;
         default:                rb_byte = fsp_pkg::RD_UNMAPPED;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      r_next           = r_reg;
      r_next.erase     = 1'b0;
      r_next.prog      = 1'b0;
      r_next.we        = 1'b0;
      r_next.lock_prog = 1'b0;
      r_next.lpm_valid = 1'b0;
      r_next.fl_rd     = 1'b0;
      r_next.rd_pend   = 1'b0;
      r_next.rd_rb     = 1'b0;
      r_next.ee_busy   = EE_BUSY_I;

      // clear first so a word stored in the same cycle survives
      if (EE_WRITE_I) begin
         r_next.valid = '0;
      end

      // second stage of a load: flash data is taken in the same cycle as the read strobe
      if (r_reg.rd_pend) begin
         r_next.lpm_valid = 1'b1;
         if (r_reg.rd_rb) begin
            r_next.lpm_data = r_reg.rb;
         end else if (r_reg.rww_busy && !in_no_read_while_write_region(page_of(r_reg.raddr))) begin
            r_next.lpm_data = fsp_pkg::RD_BLOCKED;
         end else begin
            r_next.lpm_data = FLASH_RDATA_I;
         end
      end

      // first stage of a load
      if (LINK.lpm_req) begin
         r_next.rd_pend = 1'b1;
         r_next.fl_rd   = 1'b1;
         r_next.raddr   = LINK.ptr;
      end

      case (r_reg.st)
         fsp_pkg::D_ARMED: begin
            r_next.win = r_reg.win - 3'h1;
            if (r_reg.win == 3'h1) begin
               r_next.st = fsp_pkg::D_IDLE;
            end
            if (LINK.lpm_req && r_reg.cmd == fsp_pkg::CMD_LOCK &&
                r_reg.win > fsp_pkg::LPM_LAST && !EE_BUSY_I) begin
               r_next.rd_rb = 1'b1;
               r_next.fl_rd = 1'b0;
               r_next.rb    = rb_byte(LINK.ptr);
               r_next.st    = fsp_pkg::D_IDLE;
            end else if (LINK.spm_req) begin
               r_next.st = fsp_pkg::D_IDLE;
               case (r_reg.cmd)
                  fsp_pkg::CMD_LOAD: begin
                     r_next.pbuf[word_of(LINK.ptr)]  = LINK.data_word;
                     r_next.valid[word_of(LINK.ptr)] = 1'b1;
                  end
                  fsp_pkg::CMD_ERASE,
                  fsp_pkg::CMD_WRITE: begin
                     r_next.st       = fsp_pkg::D_BUSY;
                     r_next.cnt      = '0;
                     r_next.page     = page_of(LINK.ptr);
                     r_next.erase    = (r_reg.cmd == fsp_pkg::CMD_ERASE);
                     r_next.prog     = (r_reg.cmd == fsp_pkg::CMD_WRITE);
                     r_next.op       = (r_reg.cmd == fsp_pkg::CMD_ERASE) ?
                                       fsp_pkg::OP_ERASE : fsp_pkg::OP_WRITE;
                     r_next.rww_busy = 1'b1;
                     r_next.halt     = in_no_read_while_write_region(page_of(LINK.ptr));
                  end
                  fsp_pkg::CMD_LOCK: begin
                     r_next.st        = fsp_pkg::D_BUSY;
                     r_next.cnt       = '0;
                     r_next.op        = fsp_pkg::OP_LOCK;
                     r_next.lock_prog = 1'b1;
                     r_next.lock_data = LINK.data_word[5:0];
                  end
                  default: begin
                  end
               endcase
            end
         end
         fsp_pkg::D_BUSY: begin
            r_next.cnt = r_reg.cnt + 1'b1;
            // page write streams the buffer out first; unloaded words stay erased
            if (r_reg.op == fsp_pkg::OP_WRITE && r_reg.cnt < fsp_pkg::STREAM_LEN) begin
               r_next.we    = 1'b1;
               r_next.waddr = r_reg.cnt[fsp_pkg::WORD_W-1:0];
               r_next.wdata = r_reg.valid[r_reg.cnt[fsp_pkg::WORD_W-1:0]] ?
                              r_reg.pbuf[r_reg.cnt[fsp_pkg::WORD_W-1:0]] :
                              fsp_pkg::BUF_ERASED;
            end
            if (r_reg.cnt == LAST_CNT) begin
               r_next.st   = fsp_pkg::D_IDLE;
               r_next.halt = 1'b0;
               r_next.op   = fsp_pkg::OP_NONE;
               if (r_reg.op == fsp_pkg::OP_WRITE) begin
                  r_next.valid = '0;
               end
            end
         end
         default: begin
         end
      endcase

      // control register write; commands refused while a timed operation runs
      if (LINK.ctrl_wr) begin
         r_next.ie = LINK.ctrl_wdata[fsp_pkg::IE_BIT];
         if (LINK.ctrl_wdata[fsp_pkg::EN_BIT] && !EE_BUSY_I &&
             r_next.st != fsp_pkg::D_BUSY) begin
            if (LINK.ctrl_wdata[6:0] == fsp_pkg::CMD_REEN) begin
               r_next.rww_busy = 1'b0;
               r_next.valid    = '0;
               r_next.st       = fsp_pkg::D_IDLE;
            end else begin
               r_next.st  = fsp_pkg::D_ARMED;
               r_next.cmd = LINK.ctrl_wdata[6:0];
               r_next.win = fsp_pkg::SPM_WIN;
            end
         end
      end

      // status mirror and level interrupt follow the next state
      r_next.ctrl_rd = '0;
      if (r_next.st != fsp_pkg::D_IDLE) begin
         r_next.ctrl_rd[4:0] = r_next.cmd[4:0];
      end
      r_next.ctrl_rd[fsp_pkg::BUSY_BIT] = r_next.rww_busy;
      r_next.ctrl_rd[fsp_pkg::IE_BIT]   = r_next.ie;
      r_next.irq = r_next.ie && (r_next.st == fsp_pkg::D_IDLE);
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register; reset also empties the page buffer

   always_ff @(posedge REF_CLK_I) begin
      if (RESET_I) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs, all from the state register

   assign LINK.ctrl_rdata = r_reg.ctrl_rd;
   assign LINK.lpm_valid  = r_reg.lpm_valid;
   assign LINK.lpm_data   = r_reg.lpm_data;
   assign LINK.cpu_halt   = r_reg.halt;
   assign LINK.ee_busy    = r_reg.ee_busy;
   assign LINK.irq        = r_reg.irq;
   assign FLASH_RD_O      = r_reg.fl_rd;
   assign FLASH_RADDR_O   = r_reg.raddr;
   assign FLASH_ERASE_O   = r_reg.erase;
   assign FLASH_PROG_O    = r_reg.prog;
   assign FLASH_PAGE_O    = r_reg.page;
   assign FLASH_WE_O      = r_reg.we;
   assign FLASH_WADDR_O   = r_reg.waddr;
   assign FLASH_WDATA_O   = r_reg.wdata;
   assign LOCK_PROG_O     = r_reg.lock_prog;
   assign LOCK_DATA_O     = r_reg.lock_data;

endmodule
`default_nettype wire

// *** fsp_core_end.sv ***
`default_nettype none
module fsp_core_end (
   // clock and reset
   input  wire logic        REF_CLK_I,
   input  wire logic        RESET_I,
   // request port
   input  wire logic        REQ_VALID_I,
   input  wire logic [1:0]  REQ_KIND_I,
   input  wire logic [7:0]  REQ_CTRL_I,
   input  wire logic [15:0] REQ_PTR_I,
   input  wire logic [15:0] REQ_DATA_I,
   output logic             REQ_READY_O,
   // answer port
   output logic             DONE_O,
   output logic             REFUSED_O,
   output logic [7:0]       RDATA_O,
   output logic             IRQ_O,
   // link to the controller
   fsp_link_if.core         LINK
);

   typedef struct packed {
      fsp_pkg::fsp_host_st_t           st;
      logic [1:0]                      kind;
      logic [7:0]                      ctrl;
      logic [15:0]                     ptr;
      logic [15:0]                     data;
      logic [fsp_pkg::PAGE_WORDS-1:0]  loaded;
      logic                            ready;
      logic                            done;
      logic                            refused;
      logic [7:0]                      rdata;
      logic                            irq;
      logic                            ctrl_wr;
      logic                            spm;
      logic                            lpm;
   } fsp_host_state_t;

   fsp_host_state_t h_reg;
   fsp_host_state_t h_next;
   logic [fsp_pkg::WORD_W-1:0] req_word;
   logic                       req_rww;

   // decoded request pointer
   assign req_word = REQ_PTR_I[fsp_pkg::WORD_LSB +: fsp_pkg::WORD_W];
   assign req_rww  = REQ_PTR_I[fsp_pkg::PAGE_LSB +: fsp_pkg::PAGE_W] <
                     fsp_pkg::NO_READ_WHILE_WRITE_REGION_FIRST_PAGE;

   ////////////////////////////////////////////////////////////////////////////
   // sequencer: wait, write control, issue instruction in the next cycle

   always_comb begin
      h_next         = h_reg;
      h_next.done    = 1'b0;
      h_next.refused = 1'b0;
      h_next.irq     = LINK.irq;
      case (h_reg.st)
         fsp_pkg::H_IDLE: begin
            if (REQ_VALID_I) begin
               h_next.ready = 1'b0;
               h_next.kind  = REQ_KIND_I;
               h_next.ctrl  = REQ_CTRL_I;
               h_next.ptr   = REQ_PTR_I;
               h_next.data  = REQ_DATA_I;
               h_next.st    = fsp_pkg::H_WAIT;
               if (REQ_KIND_I == fsp_pkg::KIND_STORE &&
                   REQ_CTRL_I[6:0] == fsp_pkg::CMD_LOCK) begin
                  h_next.ptr       = fsp_pkg::PTR_LOCK;
                  h_next.data[7:6] = fsp_pkg::LOCK_PAD;
               end
               // a second load to one buffer word is refused
               if (REQ_KIND_I == fsp_pkg::KIND_STORE &&
                   REQ_CTRL_I[6:0] == fsp_pkg::CMD_LOAD && h_reg.loaded[req_word]) begin
                  h_next.st      = fsp_pkg::H_IDLE;
                  h_next.refused = 1'b1;
                  h_next.ready   = 1'b1;
               end
               // program reads of the busy region are refused until re-enable
               if (REQ_KIND_I == fsp_pkg::KIND_LOAD && REQ_CTRL_I[6:0] != fsp_pkg::CMD_LOCK &&
                   req_rww && LINK.ctrl_rdata[fsp_pkg::BUSY_BIT]) begin
                  h_next.st      = fsp_pkg::H_IDLE;
                  h_next.refused = 1'b1;
                  h_next.ready   = 1'b1;
               end
            end
         end
         fsp_pkg::H_WAIT: begin
            // previous command finished, eeprom idle and core running
            if (!LINK.ctrl_rdata[fsp_pkg::EN_BIT] && !LINK.ee_busy && !LINK.cpu_halt) begin
               h_next.ctrl_wr = 1'b1;
               h_next.st      = fsp_pkg::H_CTRL;
            end
         end
         fsp_pkg::H_CTRL: begin
            h_next.ctrl_wr = 1'b0;
            h_next.spm     = (h_reg.kind == fsp_pkg::KIND_STORE);
            h_next.lpm     = (h_reg.kind == fsp_pkg::KIND_LOAD);
            h_next.st      = fsp_pkg::H_INSTR;
            if (h_reg.ctrl[6:0] == fsp_pkg::CMD_REEN || h_reg.ctrl[6:0] == fsp_pkg::CMD_WRITE) begin
               h_next.loaded = '0; // buffer is emptied by these commands
            end
            if (h_reg.kind == fsp_pkg::KIND_CTRL) begin
               h_next.st    = fsp_pkg::H_IDLE;
               h_next.done  = 1'b1;
               h_next.ready = 1'b1;
            end
         end
         fsp_pkg::H_INSTR: begin
            h_next.spm = 1'b0;
            h_next.lpm = 1'b0;
            h_next.st  = fsp_pkg::H_READ;
            if (h_reg.kind == fsp_pkg::KIND_STORE) begin
               if (h_reg.ctrl[6:0] == fsp_pkg::CMD_LOAD) begin
                  h_next.loaded[h_reg.ptr[fsp_pkg::WORD_LSB +: fsp_pkg::WORD_W]] = 1'b1;
               end
               h_next.st    = fsp_pkg::H_IDLE;
               h_next.done  = 1'b1;
               h_next.ready = 1'b1;
            end
         end
         fsp_pkg::H_READ: begin
            if (LINK.lpm_valid) begin
               h_next.rdata = LINK.lpm_data;
               h_next.st    = fsp_pkg::H_IDLE;
               h_next.done  = 1'b1;
               h_next.ready = 1'b1;
            end
         end
         default: begin
            h_next.st = fsp_pkg::H_IDLE;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register; ready is raised one cycle after reset release

   always_ff @(posedge REF_CLK_I) begin
      if (RESET_I) begin
         h_reg <= '0;
      end else begin
         h_reg <= h_next;
         if (h_reg.st == fsp_pkg::H_IDLE && !h_reg.ready && !REQ_VALID_I) begin
            h_reg.ready <= 1'b1;
         end
      end
   end

   // outputs from the state register
   assign REQ_READY_O     = h_reg.ready;
   assign DONE_O          = h_reg.done;
   assign REFUSED_O       = h_reg.refused;
   assign RDATA_O         = h_reg.rdata;
   assign IRQ_O           = h_reg.irq;
   assign LINK.ctrl_wr    = h_reg.ctrl_wr;
   assign LINK.ctrl_wdata = h_reg.ctrl;
   assign LINK.spm_req    = h_reg.spm;
   assign LINK.lpm_req    = h_reg.lpm;
   assign LINK.ptr        = h_reg.ptr;
   assign LINK.data_word  = h_reg.data;

endmodule
`default_nettype wire

// *** fsp_props.sv ***
`default_nettype none
module fsp_props (
   // clock and reset
   input wire logic        REF_CLK_I,
   input wire logic        RESET_I,
   // link signals watched
   input wire logic        ctrl_wr,
   input wire logic [7:0]  ctrl_wdata,
   input wire logic [7:0]  ctrl_rdata,
   input wire logic        spm_req,
   input wire logic        lpm_req,
   input wire logic [15:0] ptr,
   input wire logic        lpm_valid,
   input wire logic        cpu_halt,
   input wire logic        irq
);
   default clocking @(posedge REF_CLK_I); endclocking
   default disable iff (RESET_I);
   ////////////////////////////////////////////////////////////
   // armed means bit0 set with the command shown in bits 4..0
   load_answer_a: assert property (lpm_req |-> ##2 lpm_valid)
      else $error("load answer not two cycles later");
   halt_busy_a: assert property (cpu_halt |-> ctrl_rdata[0])
      else $error("halt without busy enable");
   no_read_while_write_region_halt_a: assert property (spm_req && ctrl_rdata[0] && ctrl_rdata[4:0] == 5'h03
      && ptr[15:6] >= 10'h300 |=> cpu_halt) else $error("no_read_while_write_region erase did not halt");
   rww_free_a: assert property (spm_req && ctrl_rdata[0] && ctrl_rdata[4:0] == 5'h03
      && ptr[15:6] < 10'h300 |=> !cpu_halt) else $error("rww erase halted");
   busy_set_a: assert property (spm_req && ctrl_rdata[0] && ctrl_rdata[4:0] == 5'h05
      |=> ctrl_rdata[6]) else $error("write left region free");
   // the busy flag may only go on a re-enable write; a slip here corrupts reads
   busy_hold_a: assert property (ctrl_rdata[6] && !ctrl_wr |=> ctrl_rdata[6])
      else $error("busy flag dropped by itself");
   reenable_a: assert property (ctrl_wr && ctrl_wdata[6:0] == 7'h11 && !ctrl_rdata[0]
      |=> !ctrl_rdata[6]) else $error("re-enable kept busy flag");
   arm_clear_a: assert property ($rose(ctrl_rdata[0]) ##0 (!spm_req && !lpm_req)[*4]
      |=> !ctrl_rdata[0]) else $error("armed state did not time out");
   lock_free_a: assert property (spm_req && ctrl_rdata[0] && ctrl_rdata[4:0] == 5'h09
      && !ctrl_rdata[6] |=> !ctrl_rdata[6] && !cpu_halt) else $error("lock blocked flash");
   irq_level_a: assert property ($fell(ctrl_rdata[0]) && ctrl_rdata[7] |-> ##[0:1] irq)
      else $error("no interrupt after enable cleared");
   // main scenarios reached
   erase_c: cover property (spm_req && ctrl_rdata[4:0] == 5'h03);
   load_c: cover property (lpm_valid);
   irq_c: cover property (irq);
endmodule
`default_nettype wire

// *** tb_flash_self_program_ctrl.sv ***
`default_nettype none
module tb_flash_self_program_ctrl;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] FL = 8'h62, FH = 8'hD9, FE = 8'hF9;
   localparam logic [5:0] LK = 6'h3C;
   logic        clk, rst, valid, ee_wr, rdy, done, refd, irq_o, ers, we, lprog, halt_seen;
   logic [1:0]  kind;
   logic [7:0]  ctl, rdat;
   logic [15:0] rp, dw, raddr, wd;
   logic [9:0]  page;
   logic [4:0]  wa;
   logic [5:0]  ldat;
   logic [15:0] wbuf [32];
   int          err_count = 0;
   int          cmp_count = 0;
   fsp_link_if fsp_link_if_i ();
   fsp_flash_ctrl #(.OP_CYCLES(40)) fsp_flash_ctrl_i (.REF_CLK_I(clk), .RESET_I(rst),
      .LINK(fsp_link_if_i.device), .EE_BUSY_I(1'b0), .EE_WRITE_I(ee_wr), .FUSE_LOW_I(FL),
      .FUSE_HIGH_I(FH), .FUSE_EXT_I(FE), .LOCK_STATE_I(LK), .FLASH_RDATA_I(raddr[7:0] ^ 8'hA5),
      .FLASH_RD_O(), .FLASH_RADDR_O(raddr), .FLASH_ERASE_O(ers), .FLASH_PROG_O(),
      .FLASH_PAGE_O(page), .FLASH_WE_O(we), .FLASH_WADDR_O(wa), .FLASH_WDATA_O(wd),
      .LOCK_PROG_O(lprog), .LOCK_DATA_O(ldat));
   fsp_core_end fsp_core_end_i (.REF_CLK_I(clk), .RESET_I(rst), .REQ_VALID_I(valid),
      .REQ_KIND_I(kind), .REQ_CTRL_I(ctl), .REQ_PTR_I(rp), .REQ_DATA_I(dw), .REQ_READY_O(rdy),
      .DONE_O(done), .REFUSED_O(refd), .RDATA_O(rdat), .IRQ_O(irq_o), .LINK(fsp_link_if_i.core));
   fsp_props fsp_props_i (.REF_CLK_I(clk), .RESET_I(rst), .ctrl_wr(fsp_link_if_i.ctrl_wr),
      .ctrl_wdata(fsp_link_if_i.ctrl_wdata), .ctrl_rdata(fsp_link_if_i.ctrl_rdata),
      .spm_req(fsp_link_if_i.spm_req), .lpm_req(fsp_link_if_i.lpm_req), .ptr(fsp_link_if_i.ptr),
      .lpm_valid(fsp_link_if_i.lpm_valid), .cpu_halt(fsp_link_if_i.cpu_halt), .irq(fsp_link_if_i.irq));
   ////////////////////////////////////////////////////////////
   // 25 MHz clock
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // capture the flash strobes, since they are single-cycle pulses
   always @(posedge clk) begin
      if (we) wbuf[wa] <= wd;
      if (fsp_link_if_i.cpu_halt) halt_seen <= 1'b1;
   end
   task automatic chk(input string nm, input logic [15:0] e, g);
      cmp_count++;
      if (g !== e) begin
         err_count++;
         $display("mismatch %s exp %h got %h", nm, e, g);
      end
   endtask
   // one host request; valid held until the taking edge, then wait for the answer pulse
   task automatic req(input logic [1:0] k, input logic [7:0] c, input logic [15:0] p, d);
      int n;
      @(negedge clk);
      valid = 1'b1; kind = k; ctl = c; rp = p; dw = d;
      n = 0;
      while (rdy !== 1'b1 && n < 300) begin
         @(negedge clk);
         n++;
      end
      @(negedge clk);
      valid = 1'b0;
      while (done !== 1'b1 && refd !== 1'b1 && n < 600) begin
         @(negedge clk);
         n++;
      end
      if (n >= 600) err_count++;
   endtask
   task automatic summarize();
      $display("errors %0d compares %0d", err_count, cmp_count);
      if (err_count == 0 && cmp_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////
   // every readback address, then a plain read
   task automatic t_fuse();
      logic [7:0] ex [4];
      ex = '{FL, {2'h3, LK}, FE, FH};
      for (int i = 0; i < 4; i++) begin
         req(2'h2, 8'h09, 16'(i), 16'h0000);
         chk("readback", 16'(ex[i]), 16'(rdat));
      end
      req(2'h2, 8'h00, 16'h1234, 16'h0000);
      chk("plain read", 16'h0091, 16'(rdat));
   endtask
   // erase with stray bits, fill, refused reload, write, eeprom discard, no_read_while_write_region, lock
   task automatic t_page();
      req(2'h1, 8'h03, 16'h04C3, 16'hDEAD);
      chk("erase page", 16'h0413, 16'({ers, page}));
      req(2'h1, 8'h01, 16'h04C6, 16'h1111);
      req(2'h1, 8'h81, 16'h04C0, 16'h2222);
      req(2'h1, 8'h01, 16'h04C6, 16'h3333);
      chk("reload refused", 16'h0001, 16'(refd));
      req(2'h2, 8'h00, 16'h0100, 16'h0000);
      chk("busy read refused", 16'h0001, 16'(refd));
      req(2'h1, 8'h05, 16'h04C0, 16'h0000);
      req(2'h0, 8'h11, 16'h0000, 16'h0000);
      chk("word 3", 16'h1111, wbuf[3]);
      chk("word 0", 16'h2222, wbuf[0]);
      chk("word 1", 16'hFFFF, wbuf[1]);
      req(2'h2, 8'h00, 16'h0100, 16'h0000);
      chk("read after re-enable", 16'h00A5, 16'(rdat));
      req(2'h1, 8'h01, 16'h04C4, 16'h4444);
      @(negedge clk) ee_wr = 1'b1;
      @(negedge clk) ee_wr = 1'b0;
      req(2'h1, 8'h05, 16'h04C0, 16'h0000);
      req(2'h0, 8'h11, 16'h0000, 16'h0000);
      chk("discarded word", 16'hFFFF, wbuf[2]);
      chk("cleared word", 16'hFFFF, wbuf[3]);
      req(2'h1, 8'h03, 16'hC000, 16'h0000);
      req(2'h0, 8'h11, 16'h0000, 16'h0000);
      chk("no_read_while_write_region halt", 16'h0001, 16'(halt_seen));
      req(2'h1, 8'h09, 16'h0001, 16'h00F5);
      chk("lock data", 16'h0075, 16'({lprog, ldat}));
   endtask
   // armed load pattern times out, interrupt follows while enabled
   task automatic t_irq();
      req(2'h0, 8'h81, 16'h0000, 16'h0000);
      repeat (8) @(negedge clk);
      chk("irq on", 16'h0001, 16'(irq_o));
      req(2'h0, 8'h00, 16'h0000, 16'h0000);
      repeat (4) @(negedge clk);
      chk("irq off", 16'h0000, 16'(irq_o));
   endtask
   // main sequence
   initial begin
      valid = 1'b0; kind = 2'h0; ctl = 8'h00; rp = 16'h0000; dw = 16'h0000;
      ee_wr = 1'b0; halt_seen = 1'b0; rst = 1'b1;
      repeat (8) @(negedge clk);
      rst = 1'b0;
      t_fuse();
      t_page();
      t_irq();
      summarize();
   end
   // watchdog: the run needs some 300 cycles
   initial begin
      #400000;
      err_count++;
      summarize();
   end
endmodule
`default_nettype wire
